// ===== hw/dti_pkg.sv
// Constants, types and decode helpers for the data transfer unit
package dti_pkg;
  // APB register byte offsets
  localparam logic [11:0] DTI_INSTR_OFF  = 12'h000;
  localparam logic [11:0] DTI_PC_OFF     = 12'h004;
  localparam logic [11:0] DTI_STATUS_OFF = 12'h008;
  localparam logic [11:0] DTI_TARGET_OFF = 12'h00c;
  localparam logic [11:0] DTI_RF_BASE    = 12'h040;
  localparam logic [11:0] DTI_RF_MASK    = 12'hfc3;
  // Status fields
  localparam int DTI_ST_COND    = 0;
  localparam int DTI_ST_BUSY    = 1;
  localparam int DTI_ST_ILLEGAL = 2;
  localparam int DTI_ST_TAKEN   = 3;
  // Reset values
  localparam logic [31:0] DTI_PC_RST   = 32'h0000_0000;
  localparam logic [31:0] DTI_RF_RST   = 32'h0000_0000;
  localparam logic        DTI_COND_RST = 1'b0;
  // Access sizes
  localparam logic [1:0] DTI_SZ_B = 2'h0;
  localparam logic [1:0] DTI_SZ_W = 2'h1;
  localparam logic [1:0] DTI_SZ_L = 2'h2;

  typedef enum logic [4:0] {
    OP_ILL, OP_MOVE, OP_LDPC_W, OP_LDPC_L, OP_ST, OP_LD, OP_STPD,
    OP_COPY_COND_BIT_OP, OP_COPY_INVERTED_COND_BIT_OP, OP_INVERT_COND_BIT_OP, OP_CLEAR_COND_BIT_OP, OP_SET_COND_BIT_OP, OP_SWAPB,
    OP_IMM20, OP_IMM20S, OP_BF, OP_BT
  } dti_op_e;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_MEM} dti_state_e;

  typedef struct packed {
    dti_op_e    op;
    logic [3:0] n;
    logic [3:0] m;
    logic [1:0] size;
  } dti_dec_s;

  typedef struct packed {
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dti_mem_s;

  typedef struct packed {
    logic        taken;
    logic        delayed;
    logic [31:0] target;
  } dti_br_s;

  function automatic dti_dec_s dti_decode(input logic [15:0] w);
    dti_dec_s d;
    d.n = w[11:8];
    d.m = w[7:4];
    d.size = w[1:0];
    d.op = OP_ILL;
    case (w[15:12])
      4'h9: d.op = OP_LDPC_W;
      4'hd: d.op = OP_LDPC_L;
      4'h2: begin
        if (w[3:2] == 2'h0 && w[1:0] != 2'h3) d.op = OP_ST;
        else if (w[3:2] == 2'h1 && w[1:0] != 2'h3) d.op = OP_STPD;
      end
      4'h6: begin
        if (w[3:2] == 2'h0 && w[1:0] != 2'h3) d.op = OP_LD;
        else if (w[3:0] == 4'h3) d.op = OP_MOVE;
        else if (w[3:0] == 4'h8) d.op = OP_SWAPB;
      end
      4'h0: begin
        if (w[3:0] == 4'h0) d.op = OP_IMM20;
        else if (w[3:0] == 4'h1) d.op = OP_IMM20S;
        else if (w[7:0] == 8'h29) d.op = OP_COPY_COND_BIT_OP;
        else if (w[7:0] == 8'h39) d.op = OP_COPY_INVERTED_COND_BIT_OP;
        else if (w[11:0] == 12'h068) d.op = OP_INVERT_COND_BIT_OP;
        else if (w[11:0] == 12'h008) d.op = OP_CLEAR_COND_BIT_OP;
        else if (w[11:0] == 12'h018) d.op = OP_SET_COND_BIT_OP;
      end
      4'h8: begin
        if (w[11:8] == 4'h9 || w[11:8] == 4'hd) d.op = OP_BT;
        else if (w[11:8] == 4'hb || w[11:8] == 4'hf) d.op = OP_BF;
      end
      default: d.op = OP_ILL;
    endcase
    return d;
  endfunction : dti_decode

  // Bytes moved by one access of the given size
  function automatic logic [31:0] dti_step(input logic [1:0] sz);
    return (sz == DTI_SZ_B) ? 32'h1 : (sz == DTI_SZ_W) ? 32'h2 : 32'h4;
  endfunction : dti_step

  // Loaded data placed in a register, sign-extended below a longword
  function automatic logic [31:0] dti_load_ext(input logic [1:0]  sz,
                                               input logic [31:0] d);
    if (sz == DTI_SZ_B) return {{24{d[7]}}, d[7:0]};
    if (sz == DTI_SZ_W) return {{16{d[15]}}, d[15:0]};
    return d;
  endfunction : dti_load_ext
endpackage : dti_pkg

// ===== hw/dti_core.sv
// Data transfer instruction decoder and executor with APB access
//
// Function
// - Register fields index registers 0 to 15
// - Register copy moves full source to destination
// - Word PC load: PC+disp*2, sign-extended
// - Longword PC load: PC+disp*4, unchanged
// - Indirect stores write byte, halfword, longword
// - Indirect loads: byte sign-extended, longword unchanged
// - Byte pre-decrement store subtracts one first
// - Halfword pre-decrement store subtracts two first
// - Longword pre-decrement store subtracts four first
// - One execution cycle without wait states
// - Fetch conflict stalls the data access
// - Load-use on next instruction inserts stall
// - Data transfers leave condition bit unchanged
// - Condition bit copy, inverse copy, invert, clear, set
// - Byte swap exchanges the two low bytes
// - Twenty-bit immediate loads from long instruction
// - False branch on zero, true on one
// - Immediate sign-extended, shifted form zero-filled low
// - Longword PC load masks PC low bits
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
module dti_core
  import dti_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Load/store path
  output logic             mem_req,
  output dti_mem_s         mem_o,
  input  wire logic        mem_ready,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        fetch_conflict,
  // Pipeline outputs
  output dti_br_s          branch_o,
  output logic             illegal_instr,
  output logic             cond_bit
);

  dti_state_e  state;
  logic [31:0] ir;
  logic [31:0] pc;
  logic [31:0] rf [16];
  logic        ld_pend;
  logic [3:0]  ld_reg;
  logic [3:0]  ld_dst;
  logic        illegal_seen;
  dti_dec_s    dec;
  logic        busy;
  logic        apb_acc;
  logic        apb_wr;
  logic        is_rf;
  logic        mapped;
  logic        uses_m;
  logic        uses_n;
  logic        hazard;
  logic        exec_go;
  logic        is_mem;
  logic        mem_done;
  logic [31:0] step;

  assign dec  = dti_decode(ir[15:0]);
  assign busy = (state != ST_IDLE);
  assign step = dti_step(dec.size);

  // APB decode
  assign is_rf  = ((paddr & DTI_RF_MASK) == DTI_RF_BASE);
  assign mapped = is_rf || paddr == DTI_INSTR_OFF || paddr == DTI_PC_OFF ||
                  paddr == DTI_STATUS_OFF || paddr == DTI_TARGET_OFF;
  // Writes that disturb execution wait until the unit is idle
  assign pready  = !(pwrite && busy && mapped);
  assign pslverr = psel && penable && !mapped;
  assign apb_acc = psel && penable && pready;
  assign apb_wr  = apb_acc && pwrite && mapped;

  // Operand use for load-use detection
  assign uses_m = dec.op inside {OP_MOVE, OP_ST, OP_LD, OP_STPD, OP_SWAPB};
  assign uses_n = dec.op inside {OP_ST, OP_STPD};
  assign hazard = state == ST_EXEC && ld_pend &&
                  ((uses_m && ld_reg == dec.m) ||
                   (uses_n && ld_reg == dec.n));
  assign exec_go = state == ST_EXEC && !hazard;
  assign is_mem  = dec.op inside {OP_LDPC_W, OP_LDPC_L, OP_ST, OP_LD,
                                  OP_STPD};
  // No data access while the fetch owns the path
  assign mem_req  = state == ST_MEM && !fetch_conflict;
  assign mem_done = mem_req && mem_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      if (is_rf) prdata <= rf[paddr[5:2]];
      else if (paddr == DTI_PC_OFF) prdata <= pc;
      else if (paddr == DTI_INSTR_OFF) prdata <= ir;
      else if (paddr == DTI_TARGET_OFF) prdata <= branch_o.target;
      else if (paddr == DTI_STATUS_OFF) begin
        prdata <= 32'h0;
        prdata[DTI_ST_COND]    <= cond_bit;
        prdata[DTI_ST_BUSY]    <= busy;
        prdata[DTI_ST_ILLEGAL] <= illegal_seen;
        prdata[DTI_ST_TAKEN]   <= branch_o.taken;
      end else prdata <= 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (apb_wr && paddr == DTI_INSTR_OFF) state <= ST_EXEC;
        end
        ST_EXEC: begin
          if (hazard) state <= ST_EXEC;
          else if (is_mem) state <= ST_MEM;
          else state <= ST_IDLE;
        end
        ST_MEM: begin
          if (mem_done) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir <= 32'h0;
      pc <= DTI_PC_RST;
    end else if (apb_wr) begin
      if (paddr == DTI_INSTR_OFF) ir <= pwdata;
      if (paddr == DTI_PC_OFF) pc <= pwdata;
    end
  end

  // Only one load can be outstanding, so one tracker is enough
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_pend <= 1'b0;
      ld_reg  <= 4'h0;
    end else if (mem_done && !mem_o.we) begin
      ld_pend <= 1'b1;
      ld_reg  <= ld_dst;
    end else if (state == ST_EXEC) begin
      ld_pend <= 1'b0;
    end
  end

  // Register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) rf[i] <= DTI_RF_RST;
    end else if (apb_wr && is_rf) begin
      rf[paddr[5:2]] <= pwdata;
    end else if (exec_go) begin
      case (dec.op)
        OP_MOVE:   rf[dec.n] <= rf[dec.m];
        OP_STPD:   rf[dec.n] <= rf[dec.n] - step;
        OP_COPY_COND_BIT_OP:   rf[dec.n] <= {31'h0, cond_bit};
        OP_COPY_INVERTED_COND_BIT_OP:  rf[dec.n] <= {31'h0, ~cond_bit};
        OP_SWAPB:  rf[dec.n] <= {rf[dec.m][31:16], rf[dec.m][7:0],
                                 rf[dec.m][15:8]};
        OP_IMM20:  rf[dec.n] <= {{12{ir[7]}}, ir[7:4],
                                 ir[31:16]};
        OP_IMM20S: rf[dec.n] <= {{4{ir[7]}}, ir[7:4], ir[31:16],
                                 8'h00};
        default:   ;
      endcase
    end else if (mem_done && !mem_o.we) begin
      rf[ld_dst] <= dti_load_ext(mem_o.size, mem_rdata);
    end
  end

  // Memory request, set up in the execute cycle and issued from ST_MEM
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_o  <= '0;
      ld_dst <= 4'h0;
    end else if (exec_go && is_mem) begin
      ld_dst      <= dec.n;
      mem_o.we    <= dec.op inside {OP_ST, OP_STPD};
      mem_o.size  <= dec.size;
      mem_o.wdata <= rf[dec.m];
      case (dec.op)
        OP_LDPC_W: begin
          mem_o.size <= DTI_SZ_W;
          mem_o.addr <= pc + {23'h0, ir[7:0], 1'b0};
        end
        OP_LDPC_L: begin
          mem_o.size <= DTI_SZ_L;
          mem_o.addr <= {pc[31:2], 2'b00} +
                        {22'h0, ir[7:0], 2'b00};
        end
        OP_ST:   mem_o.addr <= rf[dec.n];
        OP_LD:   mem_o.addr <= rf[dec.m];
        default: mem_o.addr <= rf[dec.n] - step;
      endcase
    end
  end

  // Condition bit; data transfers take the default branch and hold it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_bit <= DTI_COND_RST;
    end else if (exec_go) begin
      case (dec.op)
        OP_INVERT_COND_BIT_OP: cond_bit <= ~cond_bit;
        OP_CLEAR_COND_BIT_OP: cond_bit <= 1'b0;
        OP_SET_COND_BIT_OP: cond_bit <= 1'b1;
        default: cond_bit <= cond_bit;
      endcase
    end
  end

  // Branch decision pulse and target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      branch_o <= '0;
    end else begin
      branch_o.taken <= 1'b0;
      if (exec_go && dec.op inside {OP_BF, OP_BT}) begin
        branch_o.taken   <= (dec.op == OP_BT) ? cond_bit
                                              : !cond_bit;
        branch_o.delayed <= ir[10];
        branch_o.target  <= pc + {{23{ir[7]}}, ir[7:0], 1'b0};
      end
    end
  end

  // Illegal flag; cleared only by issuing a new instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      illegal_instr <= 1'b0;
      illegal_seen  <= 1'b0;
    end else begin
      illegal_instr <= exec_go && dec.op == OP_ILL;
      if (exec_go && dec.op == OP_ILL) illegal_seen <= 1'b1;
      else if (apb_wr && paddr == DTI_INSTR_OFF) illegal_seen <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence exec_s(dti_op_e o);
    exec_go && dec.op == o;
  endsequence

  move_copy_a: assert property (
    exec_s(OP_MOVE) |=> rf[$past(dec.n)] == $past(rf[dec.m]))
    else $error("register copy wrong");
  predec_a: assert property (
    exec_s(OP_STPD) |=> mem_o.addr == rf[$past(dec.n)] &&
      rf[$past(dec.n)] == $past(rf[dec.n]) - $past(step))
    else $error("pre-decrement wrong");
  ldpc_long_a: assert property (
    exec_s(OP_LDPC_L) |=> mem_o.addr[1:0] == 2'b00 &&
      mem_o.addr == {$past(pc[31:2]), 2'b00} + 4 * $past(ir[7:0]))
    else $error("longword PC address wrong");
  one_cycle_a: assert property (
    exec_go && !is_mem |=> state == ST_IDLE)
    else $error("execute took too long");
  conflict_a: assert property (
    fetch_conflict |-> !mem_req)
    else $error("data access during fetch");
  load_use_a: assert property (
    hazard |=> state == ST_EXEC && !hazard)
    else $error("load-use stall wrong");
  cond_hold_a: assert property (
    exec_go && (is_mem || dec.op == OP_MOVE) |=> $stable(cond_bit))
    else $error("condition bit changed");
  invert_cond_bit_op_a: assert property (
    exec_s(OP_INVERT_COND_BIT_OP) |=> cond_bit != $past(cond_bit))
    else $error("condition invert wrong");
  branch_a: assert property (
    exec_s(OP_BF) |=> branch_o.taken == !$past(cond_bit))
    else $error("false branch wrong");
  illegal_a: assert property (
    exec_s(OP_ILL) |=> illegal_instr ##1 !illegal_instr)
    else $error("illegal flag wrong");

  sequence load_done_s(logic [1:0] s);
    mem_done && !mem_o.we && mem_o.size == s;
  endsequence

  ldpc_word_a: assert property (
    exec_s(OP_LDPC_W) |=> !mem_o.we && mem_o.size == DTI_SZ_W &&
      mem_o.addr == $past(pc) + 2 * $past(ir[7:0]))
    else $error("word PC address wrong");
  store_req_a: assert property (
    exec_s(OP_ST) |=> mem_o.we && mem_o.addr == $past(rf[dec.n]) &&
      mem_o.wdata == $past(rf[dec.m]) && mem_o.size == $past(dec.size))
    else $error("indirect store request wrong");
  load_req_a: assert property (
    exec_s(OP_LD) |=> !mem_o.we && mem_o.addr == $past(rf[dec.m]))
    else $error("indirect load address wrong");
  load_byte_a: assert property (
    load_done_s(DTI_SZ_B) |=> rf[$past(ld_dst)] ==
      {{24{$past(mem_rdata[7])}}, $past(mem_rdata[7:0])})
    else $error("byte load not sign-extended");
  load_word_a: assert property (
    load_done_s(DTI_SZ_W) |=> rf[$past(ld_dst)] ==
      {{16{$past(mem_rdata[15])}}, $past(mem_rdata[15:0])})
    else $error("word load not sign-extended");
  load_long_a: assert property (
    load_done_s(DTI_SZ_L) |=> rf[$past(ld_dst)] == $past(mem_rdata))
    else $error("longword load altered");
  predec_step_a: assert property (
    exec_s(OP_STPD) |=> $past(rf[dec.n]) - rf[$past(dec.n)] ==
      ($past(dec.size) == DTI_SZ_B ? 32'h1 :
       $past(dec.size) == DTI_SZ_W ? 32'h2 : 32'h4))
    else $error("pre-decrement step wrong");
  clear_cond_a: assert property (
    exec_s(OP_CLEAR_COND_BIT_OP) |=> !cond_bit)
    else $error("condition clear wrong");
  set_cond_a: assert property (
    exec_s(OP_SET_COND_BIT_OP) |=> cond_bit)
    else $error("condition set wrong");
  copy_cond_a: assert property (
    exec_s(OP_COPY_COND_BIT_OP) |=> rf[$past(dec.n)] == {31'h0, $past(cond_bit)})
    else $error("condition copy wrong");
  copy_inv_a: assert property (
    exec_s(OP_COPY_INVERTED_COND_BIT_OP) |=> rf[$past(dec.n)] == {31'h0, ~$past(cond_bit)})
    else $error("inverse condition copy wrong");
  swap_bytes_a: assert property (
    exec_s(OP_SWAPB) |=> rf[$past(dec.n)][15:0] ==
      {$past(rf[dec.m][7:0]), $past(rf[dec.m][15:8])})
    else $error("byte swap wrong");
  imm_shift_a: assert property (
    exec_s(OP_IMM20S) |=> rf[$past(dec.n)][7:0] == 8'h00 &&
      rf[$past(dec.n)][31:28] == {4{$past(ir[7])}})
    else $error("shifted immediate wrong");
  branch_true_a: assert property (
    exec_s(OP_BT) |=> branch_o.taken == $past(cond_bit))
    else $error("true branch wrong");
  conflict_wait_a: assert property (
    state == ST_MEM && fetch_conflict |=> state == ST_MEM)
    else $error("access finished during fetch");

endmodule : dti_core

// ===== tb/dti_mem_model.sv
// Byte-wide memory partner on the load/store path
`timescale 1ns/1ps
module dti_mem_model
  import dti_pkg::*;
(
  // Clock
  input  wire logic       pclk,
  // Load/store path
  input  wire logic       mem_req,
  input  wire dti_mem_s   mem_o,
  output logic            mem_ready,
  output logic [31:0]     mem_rdata,
  // Wait states before each answer
  input  wire logic [1:0] lat
);
  logic [7:0]  mem [256];
  logic [1:0]  wait_cnt = 2'h0;
  logic [7:0]  a;
  logic [31:0] word;
  assign a = mem_o.addr[7:0];
  assign word = {mem[a + 8'h3], mem[a + 8'h2], mem[a + 8'h1], mem[a]};
  // Zero wait states answer in the request cycle
  assign mem_ready = mem_req && wait_cnt >= lat;
  // Inverted between answers so stale data never looks valid
  assign mem_rdata = mem_ready ? word : ~word;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hc5;
  end
  always @(posedge pclk) begin
    if (!mem_req || mem_ready) wait_cnt <= 2'h0;
    else wait_cnt <= wait_cnt + 2'h1;
    if (mem_ready && mem_o.we) begin
      for (int k = 0; k < 4; k++) begin
        if (k < (1 << mem_o.size)) mem[a + 8'(k)] = mem_o.wdata[8*k +: 8];
      end
    end
  end
endmodule : dti_mem_model

// ===== tb/dti_core_test.sv
// Self-checking bench for the data transfer unit
`timescale 1ns/1ps
module dti_core_test;
  import dti_pkg::*;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic        e;
  } dti_exp_s;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr;
  logic        mem_req, mem_ready, fetch_conflict, illegal_instr, cond_bit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_rdata, pc, v, seed = 32'd24;
  logic [31:0] r [16];
  logic [1:0]  lat;
  dti_mem_s    mem_o, m;
  dti_br_s     branch_o;
  dti_exp_s    exp_q [$];
  dti_exp_s    x;
  dti_mem_s    st_q [$];
  int          miscompares = 0, checked = 0, i;
  int          taken_n = 0, ill_n = 0, dly_n = 0;

  dti_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_o(mem_o), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
    .fetch_conflict(fetch_conflict), .branch_o(branch_o),
    .illegal_instr(illegal_instr), .cond_bit(cond_bit));
  dti_mem_model mem_u (.pclk(pclk), .mem_req(mem_req), .mem_o(mem_o),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata), .lat(lat));

  always #5 pclk = ~pclk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] mask(input logic [1:0] s);
    return s == DTI_SZ_B ? 32'hff : s == DTI_SZ_W ? 32'hffff : '1;
  endfunction : mask
  // Partner memory holds address ^ 0xc5 in every byte
  function automatic logic [31:0] word(input logic [7:0] a);
    return {a + 8'h3, a + 8'h2, a + 8'h1, a} ^ 32'hc5c5_c5c5;
  endfunction : word
  function automatic logic [11:0] rf(input logic [3:0] n);
    return DTI_RF_BASE + {6'h0, n, 2'h0};
  endfunction : rf

  task automatic report_and_stop();
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic cmp(input string nm, input logic [95:0] e,
                     input logic [95:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 500);
    if (n >= 500) begin
      cmp("pready_wait", 1, 0);
      report_and_stop();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic e = 1'b0);
    exp_q.push_back('{a, d, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wr(input logic [3:0] n, input logic [31:0] d);
    r[n] = d;
    apb(1'b1, rf(n), d);
  endtask : wr
  // The PC rewrite is held off until the unit is idle again
  task automatic exec(input logic [31:0] ins);
    apb(1'b1, DTI_INSTR_OFF, ins);
    apb(1'b1, DTI_PC_OFF, pc);
  endtask : exec
  task automatic stat(input logic c, input logic il);
    rd(DTI_STATUS_OFF, {29'h0, il, 1'b0, c});
  endtask : stat
  task automatic st(input logic [31:0] a, input logic [1:0] sz,
                    input logic [31:0] d);
    st_q.push_back('{1'b1, sz, a, d & mask(sz)});
  endtask : st

  // Random fetch conflicts and wait states
  always @(posedge pclk) begin
    fetch_conflict <= (rnd() & 32'h7) == 32'h0;
    lat <= seed[9:8];
  end
  // Result watcher
  always @(posedge pclk) begin
    if (branch_o.taken === 1'b1) taken_n++;
    if (branch_o.taken === 1'b1 && branch_o.delayed === 1'b1) dly_n++;
    if (illegal_instr === 1'b1) ill_n++;
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) cmp("read_extra", 1, 0);
      else begin
        x = exp_q.pop_front();
        cmp("prdata", {x.a, x.d, x.e}, {paddr, prdata, pslverr});
      end
    end
    if (mem_req && mem_ready && mem_o.we) begin
      m = mem_o;
      m.wdata = m.wdata & mask(m.size);
      if (st_q.size() == 0) cmp("store_extra", 1, 0);
      else cmp("store", st_q.pop_front(), m);
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    stat(1'b0, 1'b0);
    rd(12'h010, 32'h0, 1'b1);
    rd(rf(4'hf), DTI_RF_RST);
    for (i = 0; i < 16; i++) wr(4'(i), rnd());
    for (i = 0; i < 16; i++) rd(rf(4'(i)), r[i]);
    pc = 32'h32;
    apb(1'b1, DTI_PC_OFF, pc);
    wr(4'h2, 32'h40);
    exec(32'h6320);
    exec(32'h6733);
    exec(32'h6422);
    exec(32'h9507);
    exec(32'hd603);
    exec(32'h60f3);
    exec(32'h6818);
    rd(rf(4'h3), 32'hffff_ff85);
    rd(rf(4'h7), 32'hffff_ff85);
    rd(rf(4'h4), word(8'h40));
    rd(rf(4'h5), 32'hffff_8485);
    rd(rf(4'h6), word(8'h3c));
    rd(rf(4'h0), r[15]);
    rd(rf(4'h8), {r[1][31:16], r[1][7:0], r[1][15:8]});
    wr(4'h2, 32'h80);
    for (i = 0; i < 3; i++) begin
      st(r[2], 2'(i), r[1]);
      exec(32'h2210 | 32'(i));
    end
    for (i = 0; i < 3; i++) begin
      r[2] = r[2] - (32'h1 << i);
      st(r[2], 2'(i), r[1]);
      exec(32'h2214 | 32'(i));
      rd(rf(4'h2), r[2]);
    end
    exec(32'h6322);
    rd(rf(4'h3), r[1]);
    exec(32'h0018);
    exec(32'h6333);
    stat(1'b1, 1'b0);
    exec(32'h0929);
    exec(32'h0a39);
    exec(32'h0068);
    exec(32'h0b29);
    rd(rf(4'h9), 32'h1);
    rd(rf(4'ha), 32'h0);
    rd(rf(4'hb), 32'h0);
    stat(1'b0, 1'b0);
    for (i = 1; i >= 0; i--) begin
      exec(i ? 32'h0018 : 32'h0008);
      stat(i[0], 1'b0);
      exec(i ? 32'h8dfc : 32'h8bfc);
      rd(DTI_TARGET_OFF, pc - 32'h8);
      exec(i ? 32'h8ffc : 32'h89fc);
    end
    exec({16'h1234, 16'h0b80});
    exec({16'h1234, 16'h0c81});
    rd(rf(4'hb), 32'hfff8_1234);
    rd(rf(4'hc), 32'hf812_3400);
    exec(32'hffff);
    stat(1'b0, 1'b1);
    rd(rf(4'h0), r[15]);
    cmp("taken_pulses", 2, taken_n);
    cmp("illegal_pulses", 1, ill_n);
    cmp("delayed_pulses", 1, dly_n);
    cmp("cond_bit", 0, cond_bit);
    cmp("pending", 0, exp_q.size() + st_q.size());
    report_and_stop();
  end
endmodule : dti_core_test
